// >>> hdl/bso_decode.sv
`timescale 1ns/100ps
// combinational device decode; boot input unused, the caller overlays ROM 0 at zero
module bso_decode
(
	input wire logic [bso_pkg::ADDR_W-1:0] addr,
	input wire logic boot,
	input wire logic mapped_offcard,
	output bso_pkg::bso_tgt_t tgt,
	output logic sys_bus
);
	logic [2:0] region;

	always_comb
	begin
		region = addr[bso_pkg::REGION_MSB:bso_pkg::REGION_LSB];
		tgt = bso_pkg::TGT_IO;
		sys_bus = 1'b0;
		case (region)
			bso_pkg::REG_RAM:
			begin
				if (mapped_offcard)
				begin
					tgt = bso_pkg::TGT_NONE;
					sys_bus = 1'b1; // [RULE_11]
				end
				else
					tgt = bso_pkg::TGT_RAM; // [RULE_08]
			end
			bso_pkg::REG_ROM0: tgt = bso_pkg::TGT_ROM; // [RULE_14]
			bso_pkg::REG_ROM1: tgt = bso_pkg::TGT_ROM;
			default: tgt = bso_pkg::TGT_IO;
		endcase
	end
	// boot overlay handled by caller for reads only; writes fall to RAM [RULE_06]
	logic unused_boot;
	assign unused_boot = boot;
endmodule : bso_decode

// >>> hdl/bso_top.sv
`timescale 1ns/100ps
// Overview of operation
// (RULE_01) processor reset needs halt and reset low
// (RULE_02) processor-driven reset line resets whole card
// (RULE_03) any reset sets boot flip-flop
// (RULE_04) ROM enabled by decoder after reset
// (RULE_05) boot state maps ROM at address zero
// (RULE_06) vector writes reach RAM during boot
// (RULE_07) write to ROM base clears boot
// (RULE_08) after boot, zero region is RAM
// (RULE_09) system bus masters never reach on-card
// (RULE_10) on-card cycles never request system bus
// (RULE_11) system bus cycles stretched until answer; code ends the cycle with SYS_TIMEOUT_N low once wait_q reaches SYS_TIMEOUT
// (RULE_12) on-card RAM completes with no waits
// (RULE_13) internal bus is synchronous, sixteen bits
// (RULE_14) ROM 0 always at base, plus zero
// (RULE_15) boot held until clearing write completes; code clears boot on the write's first clock edge (cycle_start)
// (RULE_16) boot updated on clock, reset wins
module bso_top
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic HALT_N_IN,
	input wire logic RESET_N_IN,
	input wire logic AS_N,
	input wire logic RW,
	input wire logic [bso_pkg::ADDR_W-1:0] ADDR,
	input wire logic OFFCARD,
	input wire logic SYS_ACK,
	input wire logic EXT_MASTER_SEL,
	output logic CPU_RESET_N,
	output logic CARD_RESET_N,
	output logic BOOT_STATE,
	output logic ROM_CS,
	output logic RAM_CS,
	output logic IO_CS,
	output logic LOCAL_WE,
	output logic SYS_REQ,
	output logic DTACK_N,
	output logic SYS_TIMEOUT_N
);
	// ============================================================
	// reset
	logic card_rst;
	logic cpu_rst_d;
	logic card_rst_q;

	// both lines low resets the processor [RULE_01]
	assign cpu_rst_d = ~(~HALT_N_IN & ~RESET_N_IN);
	// processor pulling reset low resets the card [RULE_02]
	assign card_rst = ~RSTN | ~RESET_N_IN;

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			CPU_RESET_N <= 1'b0;
			card_rst_q <= 1'b1;
		end
		else
		begin
			CPU_RESET_N <= cpu_rst_d; // [RULE_01]
			card_rst_q <= ~RESET_N_IN; // [RULE_02]
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			CARD_RESET_N <= 1'b0;
		else
			CARD_RESET_N <= ~card_rst_q;
	end

	// ============================================================
	// decode
	bso_pkg::bso_tgt_t tgt;
	logic sys_bus;
	logic boot_q;
	logic boot_zero;
	logic clear_hit;
	logic local_cycle;
	logic cycle_start;
	logic as_q;

	bso_decode u_decode
	(
		.addr(ADDR),
		.boot(boot_q),
		.mapped_offcard(OFFCARD),
		.tgt(tgt),
		.sys_bus(sys_bus)
	);

	// reads of zero region fetch ROM while booting [RULE_05]
	assign boot_zero = boot_q && RW &&
		(ADDR[bso_pkg::REGION_MSB:bso_pkg::REGION_LSB] == bso_pkg::REG_RAM);
	// a system bus master writing the ROM base must not end boot state [RULE_09]
	assign clear_hit = ~AS_N && ~RW && ~EXT_MASTER_SEL && (ADDR == bso_pkg::ROM0_BASE); // [RULE_07]
	assign cycle_start = ~AS_N && as_q;

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
			as_q <= 1'b1;
		else
			as_q <= AS_N;
	end

	// ============================================================
	// boot state flip-flop
	always_ff @(posedge MCLK)
	begin
		if (card_rst)
			boot_q <= bso_pkg::BOOT_RST_VAL; // [RULE_03] [RULE_16]
		else if (clear_hit && cycle_start)
			boot_q <= 1'b0; // [RULE_07] [RULE_15]
	end

	always_ff @(posedge MCLK)
	begin
		if (card_rst)
			BOOT_STATE <= bso_pkg::BOOT_RST_VAL;
		else if (clear_hit && cycle_start)
			BOOT_STATE <= 1'b0;
	end

	// ============================================================
	// chip selects on the internal synchronous 16-bit bus
	bso_pkg::bso_state_t state_q;
	logic [7:0] wait_q;

	// external masters never select on-card devices [RULE_09]
	assign local_cycle = ~AS_N && ~EXT_MASTER_SEL && (tgt != bso_pkg::TGT_NONE || boot_zero);

	always_ff @(posedge MCLK)
	begin
		if (card_rst)
		begin
			ROM_CS <= 1'b0;
			RAM_CS <= 1'b0;
			IO_CS <= 1'b0;
			LOCAL_WE <= 1'b0;
		end
		else if (local_cycle)
		begin
			ROM_CS <= boot_zero || (tgt == bso_pkg::TGT_ROM); // [RULE_04] [RULE_05] [RULE_14]
			RAM_CS <= ~boot_zero && (tgt == bso_pkg::TGT_RAM); // [RULE_06] [RULE_08]
			IO_CS <= ~boot_zero && (tgt == bso_pkg::TGT_IO);
			LOCAL_WE <= ~RW && (tgt != bso_pkg::TGT_ROM); // [RULE_13]
		end
		else
		begin
			ROM_CS <= 1'b0;
			RAM_CS <= 1'b0;
			IO_CS <= 1'b0;
			LOCAL_WE <= 1'b0;
		end
	end

	// ============================================================
	// cycle sequencer: local done next edge, system bus waits for ack
	always_ff @(posedge MCLK)
	begin
		if (card_rst)
		begin
			state_q <= bso_pkg::ST_IDLE;
			SYS_REQ <= 1'b0;
			DTACK_N <= 1'b1;
			SYS_TIMEOUT_N <= 1'b1;
			wait_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				bso_pkg::ST_IDLE:
				begin
					DTACK_N <= 1'b1;
					SYS_TIMEOUT_N <= 1'b1;
					if (cycle_start && ~EXT_MASTER_SEL)
					begin
						if (sys_bus && ~boot_zero)
						begin
							SYS_REQ <= 1'b1; // [RULE_11]
							wait_q <= 8'h00;
							state_q <= bso_pkg::ST_SYS;
						end
						else
						begin
							// local cycles leave the system bus free [RULE_10]
							DTACK_N <= 1'b0; // [RULE_12]
							state_q <= bso_pkg::ST_DONE;
						end
					end
				end
				bso_pkg::ST_SYS:
				begin
					// stretch until the far device answers [RULE_11]
					if (SYS_ACK)
					begin
						SYS_REQ <= 1'b0;
						DTACK_N <= 1'b0;
						state_q <= bso_pkg::ST_DONE;
					end
					else if (wait_q == bso_pkg::SYS_TIMEOUT)
					begin
						// no answer: flag timeout rather than hang
						SYS_REQ <= 1'b0;
						SYS_TIMEOUT_N <= 1'b0;
						state_q <= bso_pkg::ST_DONE;
					end
					else
						wait_q <= wait_q + 8'h01;
				end
				bso_pkg::ST_DONE:
				begin
					if (AS_N)
					begin
						DTACK_N <= 1'b1;
						SYS_TIMEOUT_N <= 1'b1;
						state_q <= bso_pkg::ST_IDLE;
					end
				end
				default:
					state_q <= bso_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : bso_top

// >>> include/bso_pkg.sv
package bso_pkg;

	// address map, 24-bit processor byte address
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam logic [2:0] REG_RAM = 3'h0;
	localparam logic [2:0] REG_ROM0 = 3'h1;
	localparam logic [2:0] REG_ROM1 = 3'h2;
	localparam logic [ADDR_W-1:0] ROM0_BASE = 24'h200000;
	localparam logic [ADDR_W-1:0] VEC_LO = 24'h000008;
	localparam logic [ADDR_W-1:0] VEC_HI = 24'h0000FF;
	localparam int REGION_MSB = 23;
	localparam int REGION_LSB = 21;
	localparam logic BOOT_RST_VAL = 1'b1;

	// cycle outcome target
	typedef enum logic [1:0]
	{
		TGT_NONE = 2'h0,
		TGT_RAM = 2'h1,
		TGT_ROM = 2'h2,
		TGT_IO = 2'h3
	} bso_tgt_t;

	// bus cycle sequencer, gray along idle->sys->done; local idle->done changes both bits
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_SYS = 2'h1,
		ST_DONE = 2'h3,
		ST_WAIT_END = 2'h2
	} bso_state_t;

	localparam logic [7:0] SYS_TIMEOUT = 8'hFF;

endpackage : bso_pkg

// >>> tb/boot_state_rom_overlay_test.sv
`timescale 1ns/100ps
module boot_state_rom_overlay_test;
	logic MCLK = 0, RSTN = 0, HALT_N_IN = 1, RESET_N_IN = 1, AS_N = 1, RW = 1, OFFCARD = 0;
	logic EXT_MASTER_SEL = 0, SYS_ACK, CPU_RESET_N, CARD_RESET_N, BOOT_STATE, ROM_CS, RAM_CS;
	logic IO_CS, LOCAL_WE, SYS_REQ, DTACK_N, SYS_TIMEOUT_N;
	logic [23:0] ADDR = 24'h000000;
	logic [3:0] dly = 4'h2;
	logic [31:0] seed = 32'h02D7;
	logic [31:0] r;
	int fails = 0, samples_checked = 0, boot = 1;
	bso_top i_bso_top (.*);
	bso_sysdev i_bso_sysdev (.clk(MCLK), .req(SYS_REQ), .dly(dly), .ack(SYS_ACK));
	initial forever #2.5 MCLK = ~MCLK;
	// ==========
	// helpers
	function logic [31:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task ck(input string n, input logic [3:0] g, input int e);
		samples_checked++;
		if (g !== e[3:0])
		begin
			fails++;
			$display("FAIL %s exp %0d got %0d", n, e, g);
		end
	endtask : ck
	task complete_run;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// model: 8 io, 4 rom, 2 ram, 1 system bus, 0 refused
	task cyc(input logic [23:0] a, input logic w, input logic x);
		int e;
		e = x ? 0 : a[23:21] > 2 ? 8 : (a[23:21] != 0 || (boot && w)) ? 4 : OFFCARD ? 1 : 2;
		@(negedge MCLK);
		AS_N = 0;
		ADDR = a;
		RW = w;
		EXT_MASTER_SEL = x;
		@(negedge MCLK);
		ck("cs", {IO_CS, ROM_CS, RAM_CS, SYS_REQ}, e);
		ck("dtack", DTACK_N, e < 2);
		for (int i = 0; i < 40 && DTACK_N && e == 1; i++)
			@(negedge MCLK);
		ck("done", DTACK_N, e == 0);
		ck("tmo", SYS_TIMEOUT_N, 1);
		if (!w && a == bso_pkg::ROM0_BASE && !x)
			boot = 0;
		AS_N = 1;
		ADDR = ~a;
		EXT_MASTER_SEL = 0;
		@(negedge MCLK);
		ck("boot", BOOT_STATE, boot);
	endtask : cyc
	// ==========
	// main sequence
	initial
	begin
		repeat (6) @(negedge MCLK);
		RSTN = 1;
		ck("boot", BOOT_STATE, 1);
		cyc(24'h000008, 1, 0);
		cyc(24'h0000FE, 0, 0);
		OFFCARD = 1;
		cyc(24'h000010, 0, 0);
		cyc(24'h200000, 0, 1);
		cyc(24'h200000, 1, 0);
		cyc(24'h200000, 0, 0);
		OFFCARD = 0;
		cyc(24'h000000, 1, 0);
		repeat (24)
		begin
			r = rnd();
			OFFCARD = r[24];
			dly = r[3:0];
			cyc({r[23:1], 1'b0}, r[31], r[30] & r[29]);
		end
		HALT_N_IN = 0;
		RESET_N_IN = 0;
		repeat (3) @(negedge MCLK);
		ck("rst", {CPU_RESET_N, CARD_RESET_N}, 0);
		HALT_N_IN = 1;
		RESET_N_IN = 1;
		boot = 1;
		cyc(24'h000004, 1, 0);
		complete_run();
	end
	initial
	begin
		#100000;
		fails++;
		complete_run();
	end
endmodule : boot_state_rom_overlay_test
bind bso_top bso_chk i_bso_chk (.*);

// >>> tb/bso_chk_sva.sv
`timescale 1ns/100ps
module bso_chk
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic HALT_N_IN,
	input wire logic RESET_N_IN,
	input wire logic AS_N,
	input wire logic RW,
	input wire logic [bso_pkg::ADDR_W-1:0] ADDR,
	input wire logic OFFCARD,
	input wire logic SYS_ACK,
	input wire logic EXT_MASTER_SEL,
	input wire logic CPU_RESET_N,
	input wire logic CARD_RESET_N,
	input wire logic BOOT_STATE,
	input wire logic ROM_CS,
	input wire logic RAM_CS,
	input wire logic IO_CS,
	input wire logic LOCAL_WE,
	input wire logic SYS_REQ,
	input wire logic DTACK_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// ==========
	// cycle start
	sequence s_go;
		!EXT_MASTER_SEL && $fell(AS_N) && RESET_N_IN;
	endsequence
	sequence s_lo;
		s_go ##0 ADDR[23:21] == 3'h0;
	endsequence
	chk_cpu_reset: assert property (!HALT_N_IN && !RESET_N_IN |=> !CPU_RESET_N)
		else $error("cpu reset missing");
	chk_card_reset: assert property (!RESET_N_IN |-> ##2 !CARD_RESET_N)
		else $error("card reset missing");
	chk_boot_set: assert property (!RESET_N_IN |=> BOOT_STATE)
		else $error("boot not set");
	chk_boot_rom: assert property (s_lo ##0 BOOT_STATE && RW |=> ROM_CS && !RAM_CS && !DTACK_N)
		else $error("boot read not rom");
	chk_vec_write: assert property (s_lo ##0 BOOT_STATE && !RW && !OFFCARD |=> RAM_CS && LOCAL_WE)
		else $error("vector write lost");
	chk_boot_clear: assert property (s_go ##0 !RW && ADDR == bso_pkg::ROM0_BASE |=> !BOOT_STATE)
		else $error("boot not cleared");
	chk_ram_after: assert property (s_lo ##0 !BOOT_STATE && !OFFCARD |=> RAM_CS && !ROM_CS && !DTACK_N)
		else $error("zero not ram");
	chk_ext_refuse: assert property ($fell(AS_N) && EXT_MASTER_SEL |=> DTACK_N && !ROM_CS && !RAM_CS && !IO_CS)
		else $error("external served");
	chk_local_nosys: assert property (s_go ##0 ADDR[23:21] != 3'h0 |=> !SYS_REQ && !DTACK_N)
		else $error("local used system bus");
	chk_sys_stretch: assert property (s_lo ##0 OFFCARD && !(BOOT_STATE && RW) |=> SYS_REQ && DTACK_N)
		else $error("system cycle not stretched");
	chk_sys_done: assert property (SYS_REQ && SYS_ACK && !AS_N |=> !DTACK_N)
		else $error("system answer lost");
	chk_boot_hold: assert property (BOOT_STATE && RW |=> BOOT_STATE)
		else $error("boot dropped");
endmodule : bso_chk

// >>> tb/bso_sysdev.sv
`timescale 1ns/100ps
// ==========
// system bus responder
module bso_sysdev
(
	input wire logic clk,
	input wire logic req,
	input wire logic [3:0] dly,
	output logic ack
);
	int n = 0;
	initial ack = 1'b0;
	// ack dropped on the next falling edge after request goes, no stale answer
	always @(negedge clk)
	begin
		n <= req ? n + 1 : 0;
		ack <= req && n >= dly;
	end
endmodule : bso_sysdev
